// ==== verilog/mbr_pkg.sv ====
// constants for the read-only modbus/tcp request handler
package mbr_pkg;
  localparam logic [15:0] MBR_TCP_PORT = 16'h01f6;
  localparam logic [7:0] MBR_FC_RD_OUT = 8'h03;
  localparam logic [7:0] MBR_FC_RD_IN = 8'h04;
  localparam logic [7:0] MBR_EXC_FLAG = 8'h80;
  localparam logic [7:0] MBR_EXC_NONE = 8'h00;
  localparam logic [7:0] MBR_EXC_FUNC = 8'h01;
  localparam logic [7:0] MBR_EXC_ADDR = 8'h02;
  localparam logic [7:0] MBR_EXC_VALUE = 8'h03;
  localparam logic [15:0] MBR_QTY_MAX = 16'h007d;
  localparam logic [16:0] MBR_REG_LIMIT = 17'h00100;
  localparam logic [15:0] MBR_EXC_LEN = 16'h0003;
  localparam logic [3:0] MBR_REQ_LEN = 4'hc;
  localparam logic [3:0] MBR_MIN_LEN = 4'h8;
  localparam logic [3:0] MBR_CNT_MAX = 4'hd;
  localparam logic [3:0] MBR_HDR_LAST = 4'h8;
  // request byte positions
  localparam int MBR_B_TID_HI = 0;
  localparam int MBR_B_TID_LO = 1;
  localparam int MBR_B_PID_HI = 2;
  localparam int MBR_B_PID_LO = 3;
  localparam int MBR_B_UNIT = 6;
  localparam int MBR_B_FC = 7;
  localparam int MBR_B_ADR_HI = 8;
  localparam int MBR_B_ADR_LO = 9;
  localparam int MBR_B_QTY_HI = 10;
  localparam int MBR_B_QTY_LO = 11;
  typedef enum logic [2:0] {st_rx, st_eval, st_hdr, st_fetch, st_wait, st_data} mbr_state_t;
endpackage : mbr_pkg

// ==== verilog/mbr_server.sv ====
// read-only modbus/tcp request handler over the gateway data areas
// Overview of operation
// [R1] Function 4 reads registers 0x0000-0x00FF of the input area, two bytes each from byte zero.
// [R2] Function 3 reads the output area, register 0x0000 at byte 0x200, two bytes per register.
// [R3] Both areas are only ever read; no request alters their contents.
// [R4] Only traffic on TCP port 502 is served; frames on any other port are dropped.
// [R5] Function codes and register addressing follow standard modbus.
// [R6] With the control/status option on, register 0 returns the status word (input) or control word (output).
// [R7] Any function other than 3 or 4 is answered with exception 0x01.
// [R8] A register range beyond the data area is answered with exception 0x02.
// [R9] An illegal quantity or malformed data field is answered with exception 0x03.
// [R10] The control and status words put bits 0-7 in the first byte and the upper bits in the second.
// [R11] Lower-addressed bytes go out first, and transaction and unit ids are echoed.
`timescale 1ns/1ns
`default_nettype none
module mbr_server
  import mbr_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  input wire logic [15:0] rx_port,
  output logic rx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  input wire logic tx_ready,
  output logic [9:0] mem_addr,
  input wire logic [7:0] mem_rd_data,
  input wire logic cs_enable,
  input wire logic [15:0] status_word,
  input wire logic [15:0] control_word
);
  mbr_state_t state, next_state;
  logic [7:0] buf_q [0:11];
  logic [7:0] next_buf [0:11];
  logic [3:0] cnt, next_cnt;
  logic port_bad, next_port_bad;
  logic [3:0] hidx, next_hidx;
  logic [9:0] byte_pos, next_byte_pos;
  logic [9:0] byte_end, next_byte_end;
  logic [7:0] exc, next_exc;
  logic next_rx_ready, next_tx_valid, next_tx_last;
  logic [7:0] next_tx_data;
  logic [9:0] next_mem_addr;
  logic [15:0] qty, start, rsp_len;
  logic [16:0] reg_end;
  logic fc_in, fc_ok, can_send, area_out;
  logic [15:0] cs_word;
  logic [7:0] hdr_byte, data_byte;

  // ****************************************
  // request decode
  // ****************************************
  assign qty = {buf_q[MBR_B_QTY_HI], buf_q[MBR_B_QTY_LO]};
  assign start = {buf_q[MBR_B_ADR_HI], buf_q[MBR_B_ADR_LO]};
  assign reg_end = {1'b0, start} + {1'b0, qty};
  assign fc_in = buf_q[MBR_B_FC] == MBR_FC_RD_IN; // R5
  assign fc_ok = fc_in || (buf_q[MBR_B_FC] == MBR_FC_RD_OUT); // R5
  assign area_out = !fc_in;
  assign can_send = !tx_valid || tx_ready;
  assign rsp_len = (exc != MBR_EXC_NONE) ? MBR_EXC_LEN : MBR_EXC_LEN + {qty[14:0], 1'b0};
  assign cs_word = fc_in ? status_word : control_word; // R6

  always_comb begin
    case (hidx)
      4'h0: hdr_byte = buf_q[MBR_B_TID_HI]; // R11
      4'h1: hdr_byte = buf_q[MBR_B_TID_LO]; // R11
      4'h2: hdr_byte = 8'h00;
      4'h3: hdr_byte = 8'h00;
      4'h4: hdr_byte = rsp_len[15:8];
      4'h5: hdr_byte = rsp_len[7:0];
      4'h6: hdr_byte = buf_q[MBR_B_UNIT]; // R11
      4'h7: hdr_byte = (exc != MBR_EXC_NONE) ? (buf_q[MBR_B_FC] | MBR_EXC_FLAG) : buf_q[MBR_B_FC];
      default: hdr_byte = (exc != MBR_EXC_NONE) ? exc : {qty[6:0], 1'b0};
    endcase
  end

  // word 0 replaced by control/status, low byte first
  always_comb begin
    if (cs_enable && byte_pos[8:1] == 8'h00) begin // R6
      data_byte = byte_pos[0] ? cs_word[15:8] : cs_word[7:0]; // R10
    end else begin
      data_byte = mem_rd_data; // R11
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  always_comb begin
    next_state = state;
    next_buf = buf_q;
    next_cnt = cnt;
    next_port_bad = port_bad;
    next_hidx = hidx;
    next_byte_pos = byte_pos;
    next_byte_end = byte_end;
    next_exc = exc;
    next_tx_valid = tx_valid && !tx_ready;
    next_tx_data = tx_data;
    next_tx_last = tx_last;
    next_mem_addr = mem_addr;
    case (state)
      st_rx: begin
        if (rx_valid && rx_ready) begin
          if (cnt < MBR_REQ_LEN) begin
            next_buf[cnt] = rx_data;
          end
          if (cnt < MBR_CNT_MAX) begin
            next_cnt = cnt + 4'h1;
          end
          if (rx_port != MBR_TCP_PORT) begin
            next_port_bad = 1'b1; // R4
          end
          if (rx_last) begin
            next_state = st_eval;
          end
        end
      end
      st_eval: begin
        next_cnt = 4'h0;
        next_port_bad = 1'b0;
        next_hidx = 4'h0;
        next_byte_pos = {start[8:0], 1'b0}; // R1 R2
        next_byte_end = {reg_end[8:0], 1'b0};
        if (port_bad || cnt < MBR_MIN_LEN || buf_q[MBR_B_PID_HI] != 8'h00 || buf_q[MBR_B_PID_LO] != 8'h00) begin
          next_state = st_rx; // R4
        end else begin
          next_state = st_hdr;
          if (!fc_ok) begin
            next_exc = MBR_EXC_FUNC; // R7
          end else if (cnt != MBR_REQ_LEN || qty == 16'h0000 || qty > MBR_QTY_MAX) begin
            next_exc = MBR_EXC_VALUE; // R9
          end else if (reg_end > MBR_REG_LIMIT) begin
            next_exc = MBR_EXC_ADDR; // R8
          end else begin
            next_exc = MBR_EXC_NONE;
          end
        end
      end
      st_hdr: begin
        if (can_send) begin
          next_tx_valid = 1'b1;
          next_tx_data = hdr_byte;
          next_tx_last = (hidx == MBR_HDR_LAST) && (exc != MBR_EXC_NONE);
          next_hidx = hidx + 4'h1;
          if (hidx == MBR_HDR_LAST) begin
            next_state = (exc != MBR_EXC_NONE) ? st_rx : st_fetch;
          end
        end
      end
      st_fetch: begin
        next_mem_addr = {area_out, byte_pos[8:0]}; // R1 R2 R3
        next_state = st_wait;
      end
      st_wait: begin
        next_state = st_data;
      end
      st_data: begin
        if (can_send) begin
          next_tx_valid = 1'b1;
          next_tx_data = data_byte;
          next_byte_pos = byte_pos + 10'h001;
          next_tx_last = (byte_pos + 10'h001) == byte_end;
          next_state = ((byte_pos + 10'h001) == byte_end) ? st_rx : st_fetch;
        end
      end
      default: begin
        next_state = st_rx;
      end
    endcase
    next_rx_ready = (next_state == st_rx) && !(rx_valid && rx_ready && rx_last);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= st_rx;
      for (int i = 0; i < 12; i++) begin
        buf_q[i] <= 8'h00;
      end
      cnt <= 4'h0;
      port_bad <= 1'b0;
      hidx <= 4'h0;
      byte_pos <= 10'h000;
      byte_end <= 10'h000;
      exc <= MBR_EXC_NONE;
      rx_ready <= 1'b0;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      tx_last <= 1'b0;
      mem_addr <= 10'h000;
    end else begin
      state <= next_state;
      buf_q <= next_buf;
      cnt <= next_cnt;
      port_bad <= next_port_bad;
      hidx <= next_hidx;
      byte_pos <= next_byte_pos;
      byte_end <= next_byte_end;
      exc <= next_exc;
      rx_ready <= next_rx_ready;
      tx_valid <= next_tx_valid;
      tx_data <= next_tx_data;
      tx_last <= next_tx_last;
      mem_addr <= next_mem_addr;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  logic eval_ok;
  assign eval_ok = state == st_eval && !port_bad && cnt >= MBR_MIN_LEN && buf_q[MBR_B_PID_HI] == 8'h00
    && buf_q[MBR_B_PID_LO] == 8'h00;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  in_area_map_a: assert property (state == st_fetch && fc_in |=> mem_addr == {1'b0, $past(byte_pos[8:0])}) // R1
    else $error("input area address wrong");
  out_area_map_a: assert property (state == st_fetch && !fc_in // R2
    |=> mem_addr[9] && mem_addr[8:0] == $past(byte_pos[8:0]))
    else $error("output area address wrong");
  addr_only_fetch_a: assert property (state != st_fetch |=> $stable(mem_addr)) // R3
    else $error("memory address moved outside fetch");
  port_drop_a: assert property (state == st_eval && port_bad |=> state == st_rx ##1 !tx_valid) // R4
    else $error("frame on wrong port served");
  bad_func_a: assert property (eval_ok && !fc_ok |=> exc == MBR_EXC_FUNC && state == st_hdr) // R7
    else $error("unsupported function not refused");
  bad_addr_a: assert property (eval_ok && fc_ok && cnt == MBR_REQ_LEN && qty != 16'h0000 && qty <= MBR_QTY_MAX // R8
    && reg_end > MBR_REG_LIMIT |=> exc == MBR_EXC_ADDR)
    else $error("out of range address not refused");
  bad_value_a: assert property (eval_ok && fc_ok && (qty == 16'h0000 || qty > MBR_QTY_MAX) // R9
    |=> exc == MBR_EXC_VALUE)
    else $error("illegal quantity not refused");
  cs_word_a: assert property (state == st_data && can_send && cs_enable && byte_pos[8:0] == 9'h000 // R6 R10
    |=> tx_valid && tx_data == $past(cs_word[7:0]))
    else $error("control or status low byte not first");
  tid_echo_a: assert property (state == st_hdr && can_send && hidx == 4'h0 |=> tx_data == buf_q[MBR_B_TID_HI]) // R11
    else $error("transaction id not echoed");
  tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last)) // R11
    else $error("tx byte dropped before accepted");
  fc_decode_a: assert property (eval_ok && fc_ok && cnt == MBR_REQ_LEN && qty != 16'h0000 && qty <= MBR_QTY_MAX // R5
    && reg_end <= MBR_REG_LIMIT |=> state == st_hdr && exc == MBR_EXC_NONE)
    else $error("read function not served");

  read_in_c: cover property (state == st_data && fc_in && tx_last);
  read_out_c: cover property (state == st_data && !fc_in && tx_last);
  exc_reply_c: cover property (state == st_hdr && exc == MBR_EXC_ADDR && hidx == MBR_HDR_LAST);
  stall_c: cover property (tx_valid && !tx_ready ##1 tx_valid && tx_ready);
endmodule : mbr_server
`default_nettype wire

// ==== testbench/mbr_client.sv ====
// modbus/tcp client model: sends request frames, collects responses
`timescale 1ns/1ns
`default_nettype none
module mbr_client (
  input wire logic clk,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_last,
  output logic [15:0] rx_port,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready
);
  logic [7:0] req [0:15];
  logic [7:0] rsp [0:31];
  int rsp_n;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_last = 1'b0;
    rx_port = 16'h01f6;
    tx_ready = 1'b0;
  end
  // slow sink drops tx_ready every other cycle
  task automatic xfer(input int n, input logic [15:0] port, input bit slow);
    int k;
    int t;
    rsp_n = 0;
    for (k = 0; k < n; k++) begin
      rx_valid = 1'b1;
      rx_data = req[k];
      rx_last = (k == n - 1);
      rx_port = port;
      @(posedge clk);
      while (rx_ready !== 1'b1) @(posedge clk);
      #1;
    end
    rx_valid = 1'b0;
    rx_last = 1'b0;
    rx_data = ~rx_data;
    for (t = 0; t < 400; t++) begin
      tx_ready = slow ? t[0] : 1'b1;
      @(posedge clk);
      if (tx_valid === 1'b1 && tx_ready) begin
        rsp[rsp_n] = tx_data;
        rsp_n++;
        if (tx_last === 1'b1) t = 400;
      end
      #1;
    end
    tx_ready = 1'b0;
  endtask : xfer
endmodule : mbr_client
`default_nettype wire

// ==== testbench/mbr_server_tb_top.sv ====
// self-checking bench for the modbus/tcp request handler
`timescale 1ns/1ns
`default_nettype none
module mbr_server_tb_top;
  import mbr_pkg::*;
  logic clk, srst, rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready, cs_enable;
  logic [7:0] rx_data, tx_data, mem_rd_data;
  logic [15:0] rx_port, status_word, control_word;
  logic [9:0] mem_addr;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  mbr_server u_mbr_server (.clk(clk), .srst(srst), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_last(rx_last), .rx_port(rx_port), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .mem_addr(mem_addr),
    .mem_rd_data(mem_rd_data), .cs_enable(cs_enable), .status_word(status_word),
    .control_word(control_word));
  mbr_client u_mbr_client (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
    .rx_port(rx_port), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .tx_ready(tx_ready));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // byte pattern differs between input and output area
  function automatic logic [7:0] rom(input logic [9:0] a);
    return a[7:0] ^ {a[9:8], 6'h15};
  endfunction : rom
  always @(posedge clk) mem_rd_data <= rom(mem_addr);
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic report_and_stop;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic run(input logic [7:0] fc, input logic [15:0] st, input logic [15:0] qty,
                     input logic [15:0] port, input bit slow);
    logic [95:0] f;
    f = {st[7:0], 8'h5a, 16'h0000, 16'h0006, 8'h11, fc, st, qty};
    for (int k = 0; k < 12; k++) u_mbr_client.req[k] = f[95 - 8 * k -: 8];
    u_mbr_client.xfer(12, port, slow);
  endtask : run
  // header, then two bytes per register, lower address first
  task automatic expect_rsp(input logic [7:0] fc, input logic [15:0] st, input logic [15:0] qty,
                            input logic [7:0] exc);
    logic [71:0] h;
    logic [9:0] a;
    logic [7:0] e;
    h = {st[7:0], 8'h5a, 16'h0000, (exc != 0) ? 16'h0003 : 16'(3 + 2 * qty), 8'h11,
         (exc != 0) ? (fc | MBR_EXC_FLAG) : fc, (exc != 0) ? exc : 8'(2 * qty)};
    chk(8'(u_mbr_client.rsp_n), (exc != 0) ? 8'h09 : 8'(9 + 2 * qty));
    for (int k = 0; k < 9; k++) chk(u_mbr_client.rsp[k], h[71 - 8 * k -: 8]);
    for (int k = 0; exc == 0 && k < 2 * qty; k++) begin
      a = ((fc == MBR_FC_RD_OUT) ? 10'h200 : 10'h000) + 10'(2 * st + k);
      e = rom(a);
      if (cs_enable && st + k / 2 == 0) e = (fc == MBR_FC_RD_OUT) ? control_word[8 * k +: 8] : status_word[8 * k +: 8];
      chk(u_mbr_client.rsp[9 + k], e);
    end
  endtask : expect_rsp
  task automatic sc_read_in;
    run(MBR_FC_RD_IN, 16'h0000, 16'h0002, 16'h01f6, 1'b0);
    expect_rsp(MBR_FC_RD_IN, 16'h0000, 16'h0002, 8'h00);
  endtask : sc_read_in
  task automatic sc_read_out_slow;
    run(MBR_FC_RD_OUT, 16'h00fe, 16'h0002, 16'h01f6, 1'b1);
    expect_rsp(MBR_FC_RD_OUT, 16'h00fe, 16'h0002, 8'h00);
  endtask : sc_read_out_slow
  task automatic sc_cs_words;
    cs_enable = 1'b1;
    run(MBR_FC_RD_IN, 16'h0000, 16'h0002, 16'h01f6, 1'b0);
    expect_rsp(MBR_FC_RD_IN, 16'h0000, 16'h0002, 8'h00);
    run(MBR_FC_RD_OUT, 16'h0000, 16'h0001, 16'h01f6, 1'b0);
    expect_rsp(MBR_FC_RD_OUT, 16'h0000, 16'h0001, 8'h00);
    cs_enable = 1'b0;
  endtask : sc_cs_words
  task automatic sc_exceptions;
    run(8'h06, 16'h0001, 16'h0001, 16'h01f6, 1'b0);
    expect_rsp(8'h06, 16'h0001, 16'h0001, MBR_EXC_FUNC);
    run(MBR_FC_RD_IN, 16'h00ff, 16'h0002, 16'h01f6, 1'b0);
    expect_rsp(MBR_FC_RD_IN, 16'h00ff, 16'h0002, MBR_EXC_ADDR);
    run(MBR_FC_RD_OUT, 16'h0000, 16'h0000, 16'h01f6, 1'b0);
    expect_rsp(MBR_FC_RD_OUT, 16'h0000, 16'h0000, MBR_EXC_VALUE);
    run(MBR_FC_RD_IN, 16'h0000, 16'h007e, 16'h01f6, 1'b1);
    expect_rsp(MBR_FC_RD_IN, 16'h0000, 16'h007e, MBR_EXC_VALUE);
  endtask : sc_exceptions
  task automatic sc_wrong_port;
    run(MBR_FC_RD_IN, 16'h0000, 16'h0001, 16'h01f7, 1'b0);
    chk(8'(u_mbr_client.rsp_n), 8'h00);
  endtask : sc_wrong_port
  // short frame earns 0x03, nonzero protocol id is dropped
  task automatic sc_bad_frames;
    logic [95:0] f;
    f = {16'h005a, 16'h0000, 16'h0004, 8'h11, MBR_FC_RD_IN, 16'h0000, 16'h0000};
    for (int k = 0; k < 12; k++) u_mbr_client.req[k] = f[95 - 8 * k -: 8];
    u_mbr_client.xfer(10, 16'h01f6, 1'b0);
    expect_rsp(MBR_FC_RD_IN, 16'h0000, 16'h0000, MBR_EXC_VALUE);
    u_mbr_client.req[3] = 8'h01;
    u_mbr_client.xfer(12, 16'h01f6, 1'b0);
    chk(8'(u_mbr_client.rsp_n), 8'h00);
  endtask : sc_bad_frames
  initial begin
    srst = 1'b1;
    cs_enable = 1'b0;
    status_word = 16'hc3a1;
    control_word = 16'h7e42;
    repeat (16) @(posedge clk);
    #1;
    srst = 1'b0;
    sc_read_in();
    sc_wrong_port();
    sc_read_out_slow();
    sc_cs_words();
    sc_exceptions();
    sc_bad_frames();
    report_and_stop();
  end
endmodule : mbr_server_tb_top
`default_nettype wire
